// ### rtl/xie_pkg.sv
// Package for the extended instruction execution block: opcode fields, widths,
// reset values and the operation and sequencing enumerations.
// Assumes one core clock edge per instruction cycle.
`default_nettype none

package xie_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int DADDR_W = 12;
	localparam int PC_W = 21;

	////////////////////////////////////////////////////////////////////////////
	// Opcode fields
	localparam logic [3:0] OPC_EXT_PREFIX = 4'he;
	localparam logic [3:0] OPC_ADD_PTR = 4'h8;
	localparam logic [3:0] OPC_SUB_PTR = 4'h9;
	localparam logic [3:0] OPC_PUSH_LIT = 4'ha;
	localparam logic [3:0] OPC_MOVE = 4'hb;
	localparam logic [3:0] OPC_WORD2_PREFIX = 4'hf;
	localparam logic [15:0] OPC_COMPUTED_CALL = 16'h0014;
	localparam logic [1:0] SEL_FRAME_RET = 2'h3;
	localparam int SEL_LSB = 6;
	localparam int MOVE_FORM_BIT = 7;

	////////////////////////////////////////////////////////////////////////////
	// Addressing constants
	localparam logic [7:0] FILE_WINDOW_TOP = 8'h5f;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
	localparam logic [PC_W-1:0] RET_ADDR_STEP = 21'h000002;
	localparam logic [DADDR_W-1:0] PUSH_STEP = 12'h001;
	localparam logic [7:0] INDIRECT_READ_VALUE = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic EXT_ENABLE_RESET = 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// Enumerations
	typedef enum logic [3:0] {
		XIE_OP_NONE = 4'b0000,
		XIE_OP_ADD_PTR = 4'b0001,
		XIE_OP_ADD_RET = 4'b0010,
		XIE_OP_SUB_PTR = 4'b0011,
		XIE_OP_SUB_RET = 4'b0100,
		XIE_OP_CALL = 4'b0101,
		XIE_OP_MOV_DIR = 4'b0110,
		XIE_OP_MOV_IDX = 4'b0111,
		XIE_OP_PUSH = 4'b1000
	} xie_op_t;

	typedef enum logic [1:0] {
		XIE_ST_IDLE = 2'b00,
		XIE_ST_RET_NOP = 2'b01,
		XIE_ST_CALL_NOP = 2'b10,
		XIE_ST_MOV_W2 = 2'b11
	} xie_state_t;

endpackage

`default_nettype wire

// ### rtl/xie_decode.sv
// Opcode decoder for the eight extended instructions.
// Assumes a whole instruction word is presented; gives XIE_OP_NONE when the
// extension is off, so the standard decoder keeps those encodings.
`default_nettype none

module xie_decode
	import xie_pkg::*;
(
	input wire logic [15:0] i_word, // Instruction word
	input wire logic i_ext_en, // Extension enabled
	output xie_op_t o_op // Decoded operation
);

	////////////////////////////////////////////////////////////////////////////
	// Extended opcodes are recognised only with the extension on
	always_comb begin
		o_op = XIE_OP_NONE;
		if (i_ext_en) begin // see RL1, see RL17
			if (i_word == OPC_COMPUTED_CALL) begin
				o_op = XIE_OP_CALL;
			end else if (i_word[15:12] == OPC_EXT_PREFIX) begin
				case (i_word[11:8])
					OPC_ADD_PTR: begin
						o_op = (i_word[7:6] == SEL_FRAME_RET) ? XIE_OP_ADD_RET : XIE_OP_ADD_PTR; // see RL3
					end
					OPC_SUB_PTR: begin
						o_op = (i_word[7:6] == SEL_FRAME_RET) ? XIE_OP_SUB_RET : XIE_OP_SUB_PTR; // see RL5
					end
					OPC_PUSH_LIT: begin
						o_op = XIE_OP_PUSH;
					end
					OPC_MOVE: begin
						// Bit 7 picks the destination form
						o_op = i_word[MOVE_FORM_BIT] ? XIE_OP_MOV_IDX : XIE_OP_MOV_DIR; // see RL11
					end
					default: begin
						o_op = XIE_OP_NONE;
					end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// ### rtl/xie_idx_addr.sv
// Indexed address unit: frame pointer plus 7-bit offset, with a flag for
// addresses that land on an indirect addressing register.
// Assumes each indirect group occupies P_IND_SPAN bytes ending at its top.
`default_nettype none

module xie_idx_addr
	import xie_pkg::*;
#(
	parameter logic [3*DADDR_W-1:0] P_IND_TOPS = {12'hfdf, 12'hfe7, 12'hfef},
	parameter logic [DADDR_W-1:0] P_IND_SPAN = 12'h005
) (
	input wire logic [DADDR_W-1:0] i_base, // Frame pointer value
	input wire logic [6:0] i_offset, // Literal offset
	output logic [DADDR_W-1:0] o_addr, // Resulting data address
	output logic o_indirect // Address is an indirect register
);

	logic [2:0] hit;

	////////////////////////////////////////////////////////////////////////////
	// Sum wraps inside the 4096-byte space on purpose
	assign o_addr = i_base + {5'h00, i_offset}; // see RL9, see RL10

	// One window comparison per indirect group
	for (genvar g = 0; g < 3; g++) begin : g_ind
		assign hit[g] = (o_addr <= P_IND_TOPS[g*DADDR_W +: DADDR_W])
			&& (o_addr > P_IND_TOPS[g*DADDR_W +: DADDR_W] - P_IND_SPAN);
	end

	assign o_indirect = |hit;

endmodule

`default_nettype wire

// ### rtl/xie_exec.sv
// Execution logic for the extended instruction set and the indexed file
// operand mapping of standard instructions.
// Assumes one instruction word per valid cycle from the fetch path, a data
// memory that returns read data while o_mem_re is high, and a core that owns
// the pointers, program counter and return stack and applies the strobes here.
//
// Summary of operation
// RL1: Extension active only with enable bit; default enabled (here the reset value keeps it on until the bit loads, one cycle after release)
// RL2: Add 6-bit literal to chosen pointer, one cycle
// RL3: Select 11 adds to frame pointer, then returns
// RL4: Subtract 6-bit literal from chosen pointer, one cycle
// RL5: Select 11 subtracts from frame pointer, then returns
// RL6: Second cycle of return forms is a no-op
// RL7: Computed call pushes next address, loads counter
// RL8: Computed call leaves accumulator, flags, bank untouched
// RL9: Indexed source moved to 12-bit absolute address
// RL10: Indexed source moved to indexed destination
// RL11: Bit 7 of word one selects move form
// RL12: Software avoids counter and stack destinations
// RL13: Indirect source register reads as zero
// RL14: Indirect indexed destination makes move a no-op
// RL15: Push literal at frame pointer, then decrement
// RL16: Access operands up to 5Fh index frame pointer
// RL17: Disabled extension keeps standard direct addressing
`default_nettype none

module xie_exec
	import xie_pkg::*;
(
	input wire logic i_ref_clk, // Core clock
	input wire logic i_rst_b, // Asynchronous reset, active low
	input wire logic i_cfg_ext_enable, // Extension configuration bit
	input wire logic [15:0] i_instr, // Fetched instruction word
	input wire logic i_instr_valid, // Word is presented this cycle
	input wire logic i_std_file_op, // Word is a standard byte/bit op
	input wire logic [PC_W-1:0] i_pc, // Address of the presented word
	input wire logic [7:0] i_accum, // Accumulator value
	input wire logic [7:0] i_latch_high, // Counter latch, high byte
	input wire logic [4:0] i_latch_upper, // Counter latch, upper bits
	input wire logic [PC_W-1:0] i_return_top, // Return stack top
	input wire logic [DADDR_W-1:0] i_ptr0, // File select pointer 0
	input wire logic [DADDR_W-1:0] i_ptr1, // File select pointer 1
	input wire logic [DADDR_W-1:0] i_frame_ptr, // Stack frame pointer
	input wire logic [3:0] i_bank_sel, // Bank select register
	input wire logic [7:0] i_mem_rdata, // Data memory read data
	output logic o_ext_enabled, // Extension currently active
	output logic o_ptr_we, // Pointer write strobe
	output logic [1:0] o_ptr_sel, // Pointer being written
	output logic [DADDR_W-1:0] o_ptr_wdata, // Pointer write value
	output logic o_mem_re, // Data memory read strobe
	output logic [DADDR_W-1:0] o_mem_raddr, // Data memory read address
	output logic o_mem_we, // Data memory write strobe
	output logic [DADDR_W-1:0] o_mem_waddr, // Data memory write address
	output logic [7:0] o_mem_wdata, // Data memory write data
	output logic o_stack_push, // Push return address
	output logic [PC_W-1:0] o_stack_push_addr, // Address pushed
	output logic o_pc_we, // Program counter load strobe
	output logic [PC_W-1:0] o_pc_wdata, // Program counter load value
	output logic o_fetch_discard, // Current fetched word is dropped
	output logic o_file_addr_valid, // Standard operand address valid
	output logic [DADDR_W-1:0] o_file_addr // Standard operand address
);

	typedef struct packed {
		xie_state_t state;
		logic cfg_loaded;
		logic ext_en;
		logic mov_idx;
		logic src_ind;
		logic [7:0] rdata;
		logic ptr_we;
		logic [1:0] ptr_sel;
		logic [DADDR_W-1:0] ptr_wdata;
		logic mem_re;
		logic [DADDR_W-1:0] mem_raddr;
		logic mem_we;
		logic [DADDR_W-1:0] mem_waddr;
		logic [7:0] mem_wdata;
		logic stack_push;
		logic [PC_W-1:0] push_addr;
		logic pc_we;
		logic [PC_W-1:0] pc_wdata;
		logic discard;
		logic file_valid;
		logic [DADDR_W-1:0] file_addr;
	} xie_regs_t;

	localparam xie_regs_t REGS_RESET = '{
		state: XIE_ST_IDLE,
		cfg_loaded: 1'b0,
		ext_en: EXT_ENABLE_RESET,
		mov_idx: 1'b0,
		src_ind: 1'b0,
		rdata: 8'h00,
		ptr_we: 1'b0,
		ptr_sel: 2'h0,
		ptr_wdata: 12'h000,
		mem_re: 1'b0,
		mem_raddr: 12'h000,
		mem_we: 1'b0,
		mem_waddr: 12'h000,
		mem_wdata: 8'h00,
		stack_push: 1'b0,
		push_addr: 21'h000000,
		pc_we: 1'b0,
		pc_wdata: 21'h000000,
		discard: 1'b0,
		file_valid: 1'b0,
		file_addr: 12'h000
	};

	xie_regs_t cur;
	xie_regs_t next_regs;
	xie_op_t op;
	logic [DADDR_W-1:0] idx_addr;
	logic idx_ind;

	////////////////////////////////////////////////////////////////////////////
	// Pointer chosen by the 2-bit select field
	function automatic logic [DADDR_W-1:0] pick_ptr(input logic [1:0] sel, input logic [DADDR_W-1:0] p0,
		input logic [DADDR_W-1:0] p1, input logic [DADDR_W-1:0] p2);
		logic [DADDR_W-1:0] r;
		r = p2;
		if (sel == 2'h0) begin
			r = p0;
		end else if (sel == 2'h1) begin
			r = p1;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Decoder and shared indexed address unit
	xie_decode u_decode (
		.i_word(i_instr),
		.i_ext_en(cur.ext_en),
		.o_op(op)
	);

	// Both move words carry their offset in bits 6:0, so one unit serves both
	xie_idx_addr u_idx_addr (
		.i_base(i_frame_ptr),
		.i_offset(i_instr[6:0]),
		.o_addr(idx_addr),
		.o_indirect(idx_ind)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state: strobes are one-cycle pulses cleared every cycle
	always_comb begin
		logic [DADDR_W-1:0] ptr_val;
		logic [5:0] lit6;
		logic [7:0] move_data;
		next_regs = cur;
		ptr_val = pick_ptr(i_instr[7:6], i_ptr0, i_ptr1, i_frame_ptr);
		lit6 = i_instr[5:0];
		move_data = cur.mem_re ? i_mem_rdata : cur.rdata;
		next_regs.ptr_we = 1'b0;
		next_regs.mem_re = 1'b0;
		next_regs.mem_we = 1'b0;
		next_regs.stack_push = 1'b0;
		next_regs.pc_we = 1'b0;
		next_regs.discard = 1'b0;
		next_regs.file_valid = 1'b0;

		// Configuration bit is caught once after reset release; it cannot be
		// a reset value since it comes from another signal
		if (!cur.cfg_loaded) begin
			next_regs.cfg_loaded = 1'b1;
			next_regs.ext_en = i_cfg_ext_enable; // see RL1
		end

		// Hold read data while the second move word is awaited
		if (cur.mem_re) begin
			next_regs.rdata = i_mem_rdata;
		end

		case (cur.state)
			XIE_ST_IDLE: begin
				if (i_instr_valid) begin
					case (op)
						XIE_OP_ADD_PTR, XIE_OP_SUB_PTR: begin
							// Status flags are never touched by this block
							next_regs.ptr_we = 1'b1;
							next_regs.ptr_sel = i_instr[7:6];
							if (op == XIE_OP_ADD_PTR) begin
								next_regs.ptr_wdata = ptr_val + {6'h00, lit6}; // see RL2
							end else begin
								next_regs.ptr_wdata = ptr_val - {6'h00, lit6}; // see RL4
							end
						end
						XIE_OP_ADD_RET, XIE_OP_SUB_RET: begin
							next_regs.ptr_we = 1'b1;
							next_regs.ptr_sel = SEL_FRAME_RET - 2'h1;
							if (op == XIE_OP_ADD_RET) begin
								next_regs.ptr_wdata = i_frame_ptr + {6'h00, lit6}; // see RL3
							end else begin
								next_regs.ptr_wdata = i_frame_ptr - {6'h00, lit6}; // see RL5
							end
							next_regs.state = XIE_ST_RET_NOP;
						end
						XIE_OP_CALL: begin
							// Only the counter and stack move; accumulator and bank stay
							next_regs.stack_push = 1'b1; // see RL7, see RL8
							next_regs.push_addr = i_pc + RET_ADDR_STEP;
							next_regs.state = XIE_ST_CALL_NOP;
						end
						XIE_OP_MOV_DIR, XIE_OP_MOV_IDX: begin
							next_regs.mov_idx = (op == XIE_OP_MOV_IDX); // see RL11
							next_regs.src_ind = idx_ind;
							// Indirect sources are never read, so no pointer side effect
							next_regs.mem_re = !idx_ind; // see RL13
							next_regs.mem_raddr = idx_addr; // see RL9, see RL10
							next_regs.rdata = INDIRECT_READ_VALUE;
							next_regs.state = XIE_ST_MOV_W2;
						end
						XIE_OP_PUSH: begin
							next_regs.mem_we = 1'b1; // see RL15
							next_regs.mem_waddr = i_frame_ptr;
							next_regs.mem_wdata = i_instr[7:0];
							next_regs.ptr_we = 1'b1;
							next_regs.ptr_sel = SEL_FRAME_RET - 2'h1;
							next_regs.ptr_wdata = i_frame_ptr - PUSH_STEP;
						end
						default: begin
							// Standard operand: indexed only with extension and access bit clear
							if (i_std_file_op) begin
								next_regs.file_valid = 1'b1;
								if (!i_instr[8] && i_instr[7:0] <= FILE_WINDOW_TOP) begin
									if (cur.ext_en) begin
										next_regs.file_addr = i_frame_ptr + {4'h0, i_instr[7:0]}; // see RL16
									end else begin
										next_regs.file_addr = {4'h0, i_instr[7:0]}; // see RL17
									end
								end else if (!i_instr[8]) begin
									next_regs.file_addr = {ACCESS_HIGH_BANK, i_instr[7:0]};
								end else begin
									next_regs.file_addr = {i_bank_sel, i_instr[7:0]};
								end
							end
						end
					endcase
				end
			end
			XIE_ST_RET_NOP: begin
				// Second cycle: return and drop the word fetched behind us
				next_regs.pc_we = 1'b1; // see RL3, see RL5, see RL6
				next_regs.pc_wdata = i_return_top;
				next_regs.discard = 1'b1;
				next_regs.state = XIE_ST_IDLE;
			end
			XIE_ST_CALL_NOP: begin
				next_regs.pc_we = 1'b1; // see RL7
				next_regs.pc_wdata = {i_latch_upper, i_latch_high, i_accum};
				next_regs.discard = 1'b1;
				next_regs.state = XIE_ST_IDLE;
			end
			XIE_ST_MOV_W2: begin
				if (i_instr_valid) begin
					// Destination checks on the counter and stack are left to software
					next_regs.mem_wdata = cur.src_ind ? INDIRECT_READ_VALUE : move_data; // see RL13
					if (cur.mov_idx) begin
						next_regs.mem_waddr = idx_addr; // see RL10
						next_regs.mem_we = !idx_ind; // see RL14
					end else begin
						next_regs.mem_waddr = i_instr[DADDR_W-1:0]; // see RL9
						next_regs.mem_we = 1'b1;
					end
					next_regs.state = XIE_ST_IDLE;
				end
			end
			default: begin
				next_regs.state = XIE_ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cur <= REGS_RESET;
		end else begin
			cur <= next_regs;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign o_ext_enabled = cur.ext_en;
	assign o_ptr_we = cur.ptr_we;
	assign o_ptr_sel = cur.ptr_sel;
	assign o_ptr_wdata = cur.ptr_wdata;
	assign o_mem_re = cur.mem_re;
	assign o_mem_raddr = cur.mem_raddr;
	assign o_mem_we = cur.mem_we;
	assign o_mem_waddr = cur.mem_waddr;
	assign o_mem_wdata = cur.mem_wdata;
	assign o_stack_push = cur.stack_push;
	assign o_stack_push_addr = cur.push_addr;
	assign o_pc_we = cur.pc_we;
	assign o_pc_wdata = cur.pc_wdata;
	assign o_fetch_discard = cur.discard;
	assign o_file_addr_valid = cur.file_valid;
	assign o_file_addr = cur.file_addr;

endmodule

`default_nettype wire

// ### tb/xie_exec_assertions.sv
// Concurrent checks for the extended instruction execution block.
// Assumes it is bound to xie_exec and sees only that module's ports.
`default_nettype none

module xie_exec_assertions (
	input wire logic i_ref_clk, // Clock
	input wire logic i_rst_b, // Reset, active low
	input wire logic [15:0] i_instr, // Word
	input wire logic [20:0] i_pc, // Word address
	input wire logic [20:0] i_return_top, // Stack top
	input wire logic [11:0] i_ptr0, // Pointer 0
	input wire logic [11:0] i_ptr1, // Pointer 1
	input wire logic [11:0] i_frame_ptr, // Frame pointer
	input wire logic o_ext_enabled, // Active
	input wire logic o_ptr_we, // Ptr strobe
	input wire logic [1:0] o_ptr_sel, // Ptr select
	input wire logic [11:0] o_ptr_wdata, // Ptr value
	input wire logic o_mem_re, // Read strobe
	input wire logic [11:0] o_mem_raddr, // Read address
	input wire logic o_mem_we, // Write strobe
	input wire logic [11:0] o_mem_waddr, // Write address
	input wire logic [7:0] o_mem_wdata, // Write data
	input wire logic o_stack_push, // Push
	input wire logic [20:0] o_stack_push_addr, // Pushed
	input wire logic o_pc_we, // Counter load
	input wire logic [20:0] o_pc_wdata, // Counter value
	input wire logic o_fetch_discard, // Dropped fetch
	input wire logic o_file_addr_valid, // Operand valid
	input wire logic [11:0] o_file_addr // Operand address
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] sel_ptr;

	////////////////////////////////////////////////////////////////////////////
	// Pointer named by the select field; select 3 falls on the frame pointer
	assign sel_ptr = (i_instr[7:6] == 2'h0) ? i_ptr0 : (i_instr[7:6] == 2'h1) ? i_ptr1 : i_frame_ptr;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	////////////////////////////////////////////////////////////////////////////
	// Effects are checked back against the word that caused them
	add_ptr_a: assert property (o_ptr_we && $past(i_instr[15:8]) == 8'he8 |->
		o_ptr_wdata == $past(sel_ptr) + 12'($past(i_instr[5:0]))) else $error("pointer add wrong");
	sub_ptr_a: assert property (o_ptr_we && $past(i_instr[15:8]) == 8'he9 |->
		o_ptr_wdata == $past(sel_ptr) - 12'($past(i_instr[5:0]))) else $error("pointer subtract wrong");
	adjust_return_a: assert property (o_ptr_we && $past(i_instr[15:9]) == 7'h74 &&
		$past(i_instr[7:6]) == 2'h3 |=> o_pc_we && o_fetch_discard && o_pc_wdata == $past(i_return_top))
		else $error("return after adjust wrong");
	call_push_a: assert property (o_stack_push |-> o_stack_push_addr == $past(i_pc) + 21'h2
		##1 o_pc_we && o_fetch_discard) else $error("computed call sequence wrong");
	discard_idle_a: assert property (o_fetch_discard |->
		!o_ptr_we && !o_mem_we && !o_mem_re && !o_stack_push) else $error("work in discarded cycle");
	push_lit_a: assert property (o_mem_we && o_ptr_we |-> o_ptr_sel == 2'h2 &&
		o_ptr_wdata == o_mem_waddr - 12'h1 && o_mem_wdata == $past(i_instr[7:0])) else $error("push wrong");
	src_addr_a: assert property (o_mem_re |->
		o_mem_raddr == $past(i_frame_ptr) + 12'($past(i_instr[6:0]))) else $error("move source address wrong");
	ext_off_a: assert property (!o_ext_enabled |->
		!o_ptr_we && !o_stack_push && !o_mem_re && !o_pc_we) else $error("extended op while disabled");
	std_index_a: assert property (o_file_addr_valid && o_ext_enabled && $past(i_instr[8:0]) <= 9'h05f |->
		o_file_addr == $past(i_frame_ptr) + 12'($past(i_instr[7:0]))) else $error("indexed operand wrong");

	ret_c: cover property (o_fetch_discard);
	move_c: cover property (o_mem_we && !o_ptr_we);
	std_c: cover property (o_file_addr_valid);
endmodule

`default_nettype wire

// ### tb/xie_partner.sv
// Data memory on the far side of the block.
// Assumes writes land at the clock edge and reads answer at once.
`default_nettype none

module xie_partner (
	input wire logic i_ref_clk, // Clock
	input wire logic i_re, // Read strobe
	input wire logic [11:0] i_raddr, // Read address
	input wire logic i_we, // Write strobe
	input wire logic [11:0] i_waddr, // Write address
	input wire logic [7:0] i_wdata, // Write data
	output logic [7:0] o_rdata // Read data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [4096];
	logic [7:0] last = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Seeded so that every address within a 256-byte block reads back a distinct byte
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
	end
	// Off a read the bus shows the inverse of the last byte, so a stale value never matches
	assign o_rdata = i_re ? mem[i_raddr] : ~last;
	always @(posedge i_ref_clk) begin
		if (i_re) last <= mem[i_raddr];
		if (i_we) mem[i_waddr] <= i_wdata;
	end
endmodule

`default_nettype wire

// ### tb/tb_xie_exec.sv
// Self-checking bench for xie_exec with a data memory partner.
// Assumes the core pointers, latches and stack top are plain levels here.
`default_nettype none

module tb_xie_exec;
	import xie_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [15:0] w; logic [1:0] sel; logic [11:0] val;} xie_row_t;
	localparam xie_row_t ROWS [6] = '{'{16'he845, 2'h1, 12'h404}, '{16'he83f, 2'h0, 12'h13f},
		'{16'he8a3, 2'h2, 12'h422}, '{16'he9a3, 2'h2, 12'h3dc}, '{16'he97f, 2'h1, 12'h3c0},
		'{16'he900, 2'h0, 12'h100}};
	logic i_ref_clk = 1'b0, i_rst_b = 1'b0, i_cfg_ext_enable = 1'b1, i_instr_valid = 1'b0, i_std_file_op = 1'b0;
	logic [15:0] i_instr = 16'h0000;
	logic [20:0] i_pc = 21'h000100, i_return_top = 21'h012344;
	logic [7:0] i_accum = 8'h06, i_latch_high = 8'h10, i_mem_rdata;
	logic [4:0] i_latch_upper = 5'h01;
	logic [11:0] i_ptr0 = 12'h100, i_ptr1 = 12'h3ff, i_frame_ptr = 12'h3ff;
	logic [3:0] i_bank_sel = 4'h3;
	logic o_ext_enabled, o_ptr_we, o_mem_re, o_mem_we, o_stack_push, o_pc_we, o_fetch_discard, o_file_addr_valid;
	logic [1:0] o_ptr_sel;
	logic [11:0] o_ptr_wdata, o_mem_raddr, o_mem_waddr, o_file_addr;
	logic [7:0] o_mem_wdata;
	logic [20:0] o_stack_push_addr, o_pc_wdata;
	int mismatches = 0;
	int total_checks = 0;

	always #5 i_ref_clk = ~i_ref_clk;

	xie_exec DUT (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_cfg_ext_enable(i_cfg_ext_enable),
		.i_instr(i_instr), .i_instr_valid(i_instr_valid), .i_std_file_op(i_std_file_op), .i_pc(i_pc),
		.i_accum(i_accum), .i_latch_high(i_latch_high), .i_latch_upper(i_latch_upper),
		.i_return_top(i_return_top), .i_ptr0(i_ptr0), .i_ptr1(i_ptr1), .i_frame_ptr(i_frame_ptr),
		.i_bank_sel(i_bank_sel), .i_mem_rdata(i_mem_rdata), .o_ext_enabled(o_ext_enabled),
		.o_ptr_we(o_ptr_we), .o_ptr_sel(o_ptr_sel), .o_ptr_wdata(o_ptr_wdata), .o_mem_re(o_mem_re),
		.o_mem_raddr(o_mem_raddr), .o_mem_we(o_mem_we), .o_mem_waddr(o_mem_waddr), .o_mem_wdata(o_mem_wdata),
		.o_stack_push(o_stack_push), .o_stack_push_addr(o_stack_push_addr), .o_pc_we(o_pc_we),
		.o_pc_wdata(o_pc_wdata), .o_fetch_discard(o_fetch_discard), .o_file_addr_valid(o_file_addr_valid),
		.o_file_addr(o_file_addr));
	xie_partner u_mem (.i_ref_clk(i_ref_clk), .i_re(o_mem_re), .i_raddr(o_mem_raddr), .i_we(o_mem_we),
		.i_waddr(o_mem_waddr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

	////////////////////////////////////////////////////////////////////////////
	// Shared tasks; every input moves by non-blocking assignment at a rising edge
	// Wide enough for the broadest packed compare (push: 33 bits)
	task automatic chk(input string name, input logic [39:0] got, input logic [39:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic rst(input logic cfg);
		@(posedge i_ref_clk);
		i_rst_b <= 1'b0;
		i_cfg_ext_enable <= cfg;
		repeat (2) @(posedge i_ref_clk);
		chk("ext_in_reset", o_ext_enabled, 1);
		i_rst_b <= 1'b1;
		@(posedge i_ref_clk);
		// Let the edge that loads the configuration bit settle before looking
		#1;
	endtask
	// Hold keeps a further word up in the cycle after a return or call, which must be dropped
	task automatic op(input logic [15:0] w, input logic [11:0] fp = 12'h3ff, input logic std = 1'b0,
		input logic hold = 1'b0);
		@(posedge i_ref_clk);
		i_instr <= w;
		i_frame_ptr <= fp;
		i_std_file_op <= std;
		i_instr_valid <= 1'b1;
		@(posedge i_ref_clk);
		i_instr <= 16'he845;
		i_std_file_op <= 1'b0;
		i_instr_valid <= hold;
		#1;
	endtask
	task automatic second_cycle(input logic [20:0] pc);
		@(posedge i_ref_clk);
		i_instr_valid <= 1'b0;
		#1;
		chk("pc_load", {o_pc_we, o_fetch_discard, o_pc_wdata}, {2'b11, pc});
		// The word held up behind the return or call would show here if it ran
		chk("dropped_word", {o_ptr_we, o_stack_push, o_mem_we}, 3'b000);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence: table of pointer adjusts, then the multi-cycle and odd cases
	initial begin
		rst(1'b1);
		chk("ext_on", o_ext_enabled, 1);
		for (int i = 0; i < 6; i++) begin
			op(ROWS[i].w);
			chk("ptr_write", {o_ptr_we, o_ptr_sel, o_ptr_wdata}, {1'b1, ROWS[i].sel, ROWS[i].val});
		end
		op(16'hea08, 12'h1ec);
		chk("push", {o_mem_we, o_mem_waddr, o_mem_wdata, o_ptr_wdata}, {1'b1, 12'h1ec, 8'h08, 12'h1eb});
		op(16'he8c5, 12'h3ff, 1'b0, 1'b1);
		chk("add_ret_ptr", {o_ptr_sel, o_ptr_wdata}, {2'h2, 12'h404});
		second_cycle(21'h012344);
		op(16'he9c5, 12'h3ff, 1'b0, 1'b1);
		chk("sub_ret_ptr", {o_ptr_sel, o_ptr_wdata}, {2'h2, 12'h3fa});
		second_cycle(21'h012344);
		op(16'h0014, 12'h3ff, 1'b0, 1'b1);
		chk("call_push", {o_stack_push, o_stack_push_addr, o_ptr_we, o_mem_we}, {1'b1, 21'h000102, 2'b00});
		second_cycle(21'h011006);
		// Destinations stay off the counter and stack top bytes
		op(16'heb05, 12'h080);
		chk("mov_src", {o_mem_re, o_mem_raddr}, {1'b1, 12'h085});
		op(16'hf123, 12'h080);
		chk("mov_dir", {o_mem_we, o_mem_waddr, o_mem_wdata}, {1'b1, 12'h123, 8'hdf});
		op(16'heb85, 12'h080);
		op(16'hf006, 12'h080);
		chk("mov_idx", {o_mem_we, o_mem_waddr, o_mem_wdata}, {1'b1, 12'h086, 8'hdf});
		op(16'heb05, 12'hfd8);
		chk("ind_src_read", o_mem_re, 0);
		op(16'hf200, 12'hfd8);
		chk("ind_src_data", {o_mem_we, o_mem_wdata}, {1'b1, 8'h00});
		op(16'heb80, 12'hfd8);
		op(16'hf005, 12'hfd8);
		chk("ind_dst", o_mem_we, 0);
		op(16'heb7f, 12'hffe);
		chk("wrap_src", o_mem_raddr, 12'h07d);
		op(16'hf300, 12'hffe);
		op(16'h262c, 12'ha00, 1'b1);
		chk("std_idx", {o_file_addr_valid, o_file_addr}, {1'b1, 12'ha2c});
		op(16'h2660, 12'ha00, 1'b1);
		chk("std_access", o_file_addr, 12'hf60);
		op(16'h272c, 12'ha00, 1'b1);
		chk("std_bank", o_file_addr, 12'h32c);
		rst(1'b0);
		chk("ext_off", o_ext_enabled, 0);
		op(16'he845);
		chk("off_add", o_ptr_we, 0);
		// Disabled: a low operand stays in the low access bank, not the frame
		op(16'h262c, 12'ha00, 1'b1);
		chk("off_std", o_file_addr, 12'h02c);
		conclude();
	end

	// Watchdog well past the roughly 61 cycles the sequence needs
	initial begin
		#20000;
		mismatches++;
		conclude();
	end
endmodule

bind xie_exec xie_exec_assertions u_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_instr(i_instr),
	.i_pc(i_pc), .i_return_top(i_return_top), .i_ptr0(i_ptr0), .i_ptr1(i_ptr1), .i_frame_ptr(i_frame_ptr),
	.o_ext_enabled(o_ext_enabled), .o_ptr_we(o_ptr_we), .o_ptr_sel(o_ptr_sel), .o_ptr_wdata(o_ptr_wdata),
	.o_mem_re(o_mem_re), .o_mem_raddr(o_mem_raddr), .o_mem_we(o_mem_we), .o_mem_waddr(o_mem_waddr),
	.o_mem_wdata(o_mem_wdata), .o_stack_push(o_stack_push), .o_stack_push_addr(o_stack_push_addr),
	.o_pc_we(o_pc_we), .o_pc_wdata(o_pc_wdata), .o_fetch_discard(o_fetch_discard),
	.o_file_addr_valid(o_file_addr_valid), .o_file_addr(o_file_addr));

`default_nettype wire
